// File: src/mam_blink.sv
// blink pattern generator: count pulses then a dark pause, repeating
`timescale 1ns/10ps
module mam_blink import mam_pkg::*; #(
   parameter int HALF_CYC = BLINK_HALF_CYC // cycles per on or off slot
) (
   input wire logic clk_sys_i, // system clock
   input wire logic rst_i, // synchronous reset
   mam_blink_if.gen bl // pattern request and led
);
   logic [31:0] tick; // cycles within a slot
   logic [4:0] slot; // slot within a cycle
   logic [4:0] last_slot; // final slot of a cycle
   logic led; // registered led

   assign last_slot = 5'({bl.count, 1'b0}) + 5'(BLINK_PAUSE_SLOTS - 1);
   assign bl.led = led;

   // slot timing, restarts whenever the pattern is off
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || !bl.run) begin
         tick <= '0;
         slot <= '0;
      end else if (tick == 32'(HALF_CYC - 1)) begin
         tick <= '0;
         slot <= (slot >= last_slot) ? 5'd0 : slot + 5'd1;
      end else begin
         tick <= tick + 32'd1;
      end
   end

   // even slots inside the pulse train light the led
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         led <= 1'b0;
      end else begin
         led <= bl.run && (slot < 5'({bl.count, 1'b0})) && !slot[0];
      end
   end
endmodule

// File: src/mam_blink_if.sv
// carrier between the monitor and one indicator blink generator
`timescale 1ns/10ps
interface mam_blink_if;
   logic run; // pattern enabled
   logic [3:0] count; // blinks per cycle
   logic led; // indicator drive
   modport ctrl (output run, output count, input led);
   modport gen (input run, input count, output led);
endinterface

// File: src/mam_monitor.sv
// supply alarm and information monitor with apb registers and indicator
`timescale 1ns/10ps
module mam_monitor import mam_pkg::*; #(
   parameter int HALF_CYC = BLINK_HALF_CYC // indicator slot length in cycles
) (
   input wire logic clk_sys_i, // system clock, 50 MHz
   input wire logic rst_i, // power-on reset, synchronous
   input wire logic [9:0] supply_dv_i, // main supply in 0.1 V
   input wire logic cpu_fault_i, // temperature or circuit fault
   input wire logic alarm_clear_input_i, // alarm reset input
   input wire logic serial_reset_i, // reset command from serial link
   input wire logic brake_release_req_i, // motion wants brake released
   output logic motor_stop_o, // stop motion
   output logic winding_enable_o, // winding current on
   output logic brake_release_o, // brake released
   output logic supply_high_info_bit_o, // overvoltage information
   output logic supply_low_info_bit_o, // undervoltage information
   output logic [7:0] alarm_code_o, // active alarm code
   output logic ind_red_o, // combined_state_indicator red
   output logic ind_blue_o, // combined_state_indicator blue
   output logic irq_o, // interrupt level
   input wire logic psel_i, // apb select
   input wire logic penable_i, // apb enable
   input wire logic pwrite_i, // apb direction
   input wire logic [7:0] paddr_i, // apb byte address
   input wire logic [31:0] pwdata_i, // apb write data
   output logic [31:0] prdata_o, // apb read data
   output logic pready_o, // apb ready
   output logic pslverr_o // apb error
);
   logic mode48; // main power mode is 48 V
   logic [9:0] ov_thr; // overvoltage info threshold
   logic [9:0] uv_thr; // undervoltage info threshold
   logic [3:0] irq_stat; // sticky events
   logic [3:0] irq_mask; // event enables
   logic ov_alarm; // latched overvoltage alarm
   logic cpu_alarm; // latched cpu circuit alarm
   logic clr_prev; // reset input last cycle
   logic clr_rise; // reset input rising edge
   logic sw_reset; // apb reset command pulse
   logic clear_req; // any non-power reset
   logic ov_over; // supply above alarm limit
   logic [9:0] ov_limit; // selected alarm limit
   logic alarm_any; // some alarm latched
   logic info_any; // some information active
   logic [3:0] events; // event pulses
   logic wr_en; // apb write strobe
   logic mapped; // address decodes
   logic [31:0] rd_mux; // read data selection
   logic [31:0] status_word; // status register view
   logic [9:0] wr_thr; // clamped threshold write
   logic [3:0] next_irq_stat; // next sticky events
   mam_blink_if red_if (); // red pattern
   mam_blink_if blue_if (); // blue pattern

   // limit and edge decode
   assign ov_limit = mode48 ? OV_LIMIT_48V : OV_LIMIT_24V; // see RULE8
   assign ov_over = supply_dv_i > ov_limit; // see RULE8
   assign clr_rise = alarm_clear_input_i && !clr_prev; // see RULE3
   assign clear_req = clr_rise || serial_reset_i || sw_reset; // see RULE4
   assign alarm_any = ov_alarm || cpu_alarm;
   assign info_any = supply_high_info_bit_o || supply_low_info_bit_o;

   // apb decode, zero wait states
   assign wr_en = psel_i && penable_i && pwrite_i;
   always_comb begin
      mapped = 1'b1;
      case (paddr_i)
         OFS_CTRL, OFS_OV_THR, OFS_UV_THR: mapped = 1'b1;
         OFS_STATUS, OFS_IRQ_STAT, OFS_IRQ_MASK: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !mapped;

   // threshold writes are held inside the legal range
   always_comb begin
      wr_thr = pwdata_i[VOLT_W-1:0];
      if (pwdata_i[31:VOLT_W] != '0 || wr_thr > THR_MAX) begin
         wr_thr = THR_MAX; // see RULE12
      end else if (wr_thr < THR_MIN) begin
         wr_thr = THR_MIN; // see RULE12
      end
   end

   // control and threshold registers
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         mode48 <= CTRL_MODE48_RST;
         ov_thr <= OV_THR_RST; // see RULE12
         uv_thr <= UV_THR_RST; // see RULE12
         irq_mask <= IRQ_MASK_RST;
      end else if (wr_en) begin
         case (paddr_i)
            OFS_CTRL: mode48 <= pwdata_i[CTRL_MODE48_BIT];
            OFS_OV_THR: ov_thr <= wr_thr;
            OFS_UV_THR: uv_thr <= wr_thr;
            OFS_IRQ_MASK: irq_mask <= pwdata_i[EV_WIDTH-1:0];
            default: ;
         endcase
      end
   end

   // software alarm reset command, one cycle pulse
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         sw_reset <= 1'b0;
      end else begin
         sw_reset <= wr_en && paddr_i == OFS_CTRL && pwdata_i[CTRL_RESET_BIT];
      end
   end

   // reset input history for edge detection
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         clr_prev <= 1'b0;
      end else begin
         clr_prev <= alarm_clear_input_i;
      end
   end

   // overvoltage alarm latch, a present cause wins over a reset, see RULE13
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ov_alarm <= 1'b0; // see RULE5
      end else if (ov_over) begin
         ov_alarm <= 1'b1; // see RULE8
      end else if (clear_req) begin
         ov_alarm <= 1'b0; // see RULE6
      end
   end

   // cpu circuit alarm, only the power-on reset clears it
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cpu_alarm <= 1'b0; // see RULE5
      end else if (cpu_fault_i) begin
         cpu_alarm <= 1'b1; // see RULE7
      end
   end

   // information bits with hold at equality
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         supply_high_info_bit_o <= 1'b0;
         supply_low_info_bit_o <= 1'b0;
      end else begin
         if (supply_dv_i > ov_thr) begin
            supply_high_info_bit_o <= 1'b1; // see RULE10
         end else if (supply_dv_i < ov_thr) begin
            supply_high_info_bit_o <= 1'b0; // see RULE10
         end
         if (supply_dv_i < uv_thr) begin
            supply_low_info_bit_o <= 1'b1; // see RULE11
         end else if (supply_dv_i > uv_thr) begin
            supply_low_info_bit_o <= 1'b0; // see RULE11
         end
      end
   end

   // motor and brake outputs follow the alarm state
   assign motor_stop_o = alarm_any; // see RULE1
   assign winding_enable_o = !alarm_any; // see RULE2
   assign brake_release_o = brake_release_req_i && !alarm_any; // see RULE2

   // alarm code, cpu alarm takes precedence
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         alarm_code_o <= ALM_CODE_NONE;
      end else if (cpu_fault_i || cpu_alarm) begin
         alarm_code_o <= ALM_CODE_CPU; // see RULE7
      end else if (ov_over || (ov_alarm && !clear_req)) begin
         alarm_code_o <= ALM_CODE_OV; // see RULE6
      end else begin
         alarm_code_o <= ALM_CODE_NONE;
      end
   end

   // indicator patterns: red on alarm, blue on information only
   assign red_if.run = alarm_any; // see RULE1
   assign red_if.count = cpu_alarm ? BLINKS_CPU : BLINKS_OV; // see RULE6
   assign blue_if.run = info_any && !alarm_any; // see RULE9
   assign blue_if.count = BLINKS_INFO;
   assign ind_red_o = red_if.led;
   assign ind_blue_o = blue_if.led;

   mam_blink #(.HALF_CYC(HALF_CYC)) u_red (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .bl(red_if)
   );
   mam_blink #(.HALF_CYC(HALF_CYC)) u_blue (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .bl(blue_if)
   );

   // event pulses: alarm latch and information rising
   assign events[ST_OV_ALARM_BIT] = ov_over && !ov_alarm;
   assign events[ST_CPU_ALARM_BIT] = cpu_fault_i && !cpu_alarm;
   assign events[ST_INFO_HIGH_BIT] = supply_dv_i > ov_thr && !supply_high_info_bit_o;
   assign events[ST_INFO_LOW_BIT] = supply_dv_i < uv_thr && !supply_low_info_bit_o;

   // sticky status, write one clears, a new event wins
   always_comb begin
      next_irq_stat = irq_stat;
      if (wr_en && paddr_i == OFS_IRQ_STAT) begin
         next_irq_stat = irq_stat & ~pwdata_i[EV_WIDTH-1:0];
      end
      next_irq_stat = next_irq_stat | events;
   end
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         irq_stat <= '0;
      end else begin
         irq_stat <= next_irq_stat;
      end
   end
   assign irq_o = |(irq_stat & irq_mask);

   // read view
   always_comb begin
      status_word = '0;
      status_word[ST_OV_ALARM_BIT] = ov_alarm;
      status_word[ST_CPU_ALARM_BIT] = cpu_alarm;
      status_word[ST_INFO_HIGH_BIT] = supply_high_info_bit_o;
      status_word[ST_INFO_LOW_BIT] = supply_low_info_bit_o;
      status_word[ST_CODE_LSB +: 8] = alarm_code_o;
      case (paddr_i)
         OFS_CTRL: rd_mux = {31'd0, mode48};
         OFS_OV_THR: rd_mux = {22'd0, ov_thr};
         OFS_UV_THR: rd_mux = {22'd0, uv_thr};
         OFS_STATUS: rd_mux = status_word;
         OFS_IRQ_STAT: rd_mux = {28'd0, irq_stat};
         OFS_IRQ_MASK: rd_mux = {28'd0, irq_mask};
         default: rd_mux = '0;
      endcase
   end

   // read data captured in the setup cycle
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         prdata_o <= '0;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         prdata_o <= rd_mux;
      end
   end

   // checks
   chk_stop_on_alarm: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $rose(ov_alarm) |-> motor_stop_o && !winding_enable_o && red_if.run) // see RULE1
      else $error("alarm did not stop the motor");
   chk_brake_holds: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      alarm_any |-> !brake_release_o && !winding_enable_o) // see RULE2
      else $error("brake released or winding on during alarm");
   chk_level_no_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ov_alarm && alarm_clear_input_i && clr_prev && !serial_reset_i && !sw_reset
      |=> ov_alarm) // see RULE3
      else $error("held reset level cleared the alarm");
   chk_edge_clears: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ov_alarm && !ov_over && (clr_rise || serial_reset_i) |=> !ov_alarm) // see RULE4
      else $error("reset request did not clear the alarm");
   chk_power_clear: assert property (@(posedge clk_sys_i)
      rst_i |=> !ov_alarm && !cpu_alarm) // see RULE5
      else $error("power cycle left an alarm");
   chk_ov_code: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $past(ov_alarm) && ov_alarm && !cpu_alarm && !$past(cpu_fault_i)
      |-> alarm_code_o == ALM_CODE_OV && red_if.count == BLINKS_OV) // see RULE6
      else $error("wrong overvoltage code or blinks");
   chk_cpu_sticky: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      cpu_alarm |=> cpu_alarm && alarm_code_o == ALM_CODE_CPU
      && red_if.count == BLINKS_CPU) // see RULE7
      else $error("cpu alarm cleared or wrong code");
   chk_ov_limit: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      supply_dv_i > (mode48 ? OV_LIMIT_48V : OV_LIMIT_24V) |=> ov_alarm) // see RULE8
      else $error("overvoltage alarm missed");
   chk_blue_info: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      info_any && !alarm_any |-> blue_if.run && !motor_stop_o && !red_if.run) // see RULE9
      else $error("information did not blink blue");
   chk_info_high: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      supply_dv_i > ov_thr ##1 supply_dv_i < ov_thr |-> supply_high_info_bit_o ##1
      !supply_high_info_bit_o) // see RULE10
      else $error("high information set or clear wrong");
   chk_info_low: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      supply_dv_i < uv_thr |=> supply_low_info_bit_o) // see RULE11
      else $error("low information not set");
   chk_thr_range: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ov_thr >= THR_MIN && ov_thr <= THR_MAX && uv_thr >= THR_MIN
      && uv_thr <= THR_MAX) // see RULE12
      else $error("threshold out of range");
   chk_alarm_latched: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      ov_alarm && !clear_req |=> ov_alarm) // see RULE13
      else $error("alarm dropped without reset");
   cov_ov_cleared: cover property (@(posedge clk_sys_i) disable iff (rst_i)
      ov_alarm ##1 !ov_alarm);
   cov_cpu_alarm: cover property (@(posedge clk_sys_i) disable iff (rst_i)
      $rose(cpu_alarm));
   cov_info_low: cover property (@(posedge clk_sys_i) disable iff (rst_i)
      $rose(supply_low_info_bit_o));
endmodule

// File: src/mam_pkg.sv
// constants, register map and codes of the motor alarm and information monitor
// Overview of operation
// RULE1 - alarm stops motor, indicator blinks red
// RULE2 - alarm cuts winding current, brake keeps holding
// RULE3 - resettable alarm clears on input rising edge
// RULE4 - serial reset command acts like input edge
// RULE5 - power cycle clears every alarm
// RULE6 - overvoltage alarm: code 22h, 3 blinks
// RULE7 - cpu circuit alarm: code 29h, 9 blinks, power-only
// RULE8 - overvoltage limit 36 V or 63 V by mode
// RULE9 - information blinks blue, motor keeps running
// RULE10 - high info set above threshold, self-clears
// RULE11 - low info set below threshold, self-clears
// RULE12 - thresholds 140..630 in 0.1 V, defaults 630/140
// RULE13 - alarm stays latched until permitted reset
package mam_pkg;
   // apb register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_OV_THR = 8'h04;
   localparam logic [7:0] OFS_UV_THR = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
   // control fields
   localparam int CTRL_MODE48_BIT = 0;
   localparam int CTRL_RESET_BIT = 1;
   localparam logic CTRL_MODE48_RST = 1'b0;
   // status fields
   localparam int ST_OV_ALARM_BIT = 0;
   localparam int ST_CPU_ALARM_BIT = 1;
   localparam int ST_INFO_HIGH_BIT = 2;
   localparam int ST_INFO_LOW_BIT = 3;
   localparam int ST_CODE_LSB = 8;
   // event bits, same layout for status and mask
   localparam int EV_WIDTH = 4;
   localparam logic [3:0] IRQ_MASK_RST = 4'h0;
   // voltages in 0.1 V units
   localparam int VOLT_W = 10;
   localparam logic [9:0] THR_MIN = 10'h08C;
   localparam logic [9:0] THR_MAX = 10'h276;
   localparam logic [9:0] OV_THR_RST = 10'h276;
   localparam logic [9:0] UV_THR_RST = 10'h08C;
   localparam logic [9:0] OV_LIMIT_24V = 10'h168;
   localparam logic [9:0] OV_LIMIT_48V = 10'h276;
   // alarm codes and blink counts
   localparam logic [7:0] ALM_CODE_NONE = 8'h00;
   localparam logic [7:0] ALM_CODE_OV = 8'h22;
   localparam logic [7:0] ALM_CODE_CPU = 8'h29;
   localparam logic [3:0] BLINKS_OV = 4'h3;
   localparam logic [3:0] BLINKS_CPU = 4'h9;
   localparam logic [3:0] BLINKS_INFO = 4'h1;
   // indicator timing
   localparam int CLK_MHZ = 50;
   localparam int BLINK_HALF_MS = 200;
   localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
   localparam int BLINK_PAUSE_SLOTS = 4;
endpackage

// File: testbench/mam_host.sv
// host controller model: alarm clear input edges and serial reset commands
`timescale 1ns/10ps
module mam_host (
   input wire logic clk_sys_i, // system clock
   input wire logic rst_i, // synchronous reset
   input wire logic edge_req_i, // request one high pulse on the clear input
   input wire logic serial_req_i, // request one serial reset command
   input wire logic hold_i, // keep the clear input high as a steady level
   output logic alarm_clear_input_o, // alarm reset input of the device
   output logic serial_reset_o // one-cycle serial reset command
);
   logic [1:0] edge_cnt; // remaining high cycles of the clear pulse
   // clear pulse lasts two cycles, so the device sees an off-to-on edge
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         edge_cnt <= 2'h0;
      end else if (edge_req_i) begin
         edge_cnt <= 2'h2;
      end else if (edge_cnt != 2'h0) begin
         edge_cnt <= edge_cnt - 2'h1;
      end
   end
   // a serial command is delivered as a single-cycle pulse
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         serial_reset_o <= 1'b0;
      end else begin
         serial_reset_o <= serial_req_i;
      end
   end
   // steady level or pulse, whichever is asked for
   assign alarm_clear_input_o = hold_i | (edge_cnt != 2'h0);
endmodule

// File: testbench/motor_driver_alarm_info_monitor_bench.sv
// self-checking bench of the alarm and information monitor
`timescale 1ns/10ps
module motor_driver_alarm_info_monitor_bench;
   import mam_pkg::*;
   localparam int HALF = 4; // short indicator slot for simulation
   logic clk_sys_i = 1'b0, rst_i = 1'b1, cpu_fault_i = 1'b0, brake_req = 1'b0;
   logic [9:0] supply = 10'h0F0; // 24.0 V nominal, below both alarm limits
   logic edge_req = 1'b0, serial_req = 1'b0, hold = 1'b0, clr_in, ser_rst;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [7:0] paddr = 8'h00, code;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic stop, wind, brake, hi, lo, red, blue, irq;
   int errors = 0, check_count = 0, cycles = 0, n;
   always #10 clk_sys_i = ~clk_sys_i; // 50 MHz
   mam_monitor #(.HALF_CYC(HALF)) DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .supply_dv_i(supply), .cpu_fault_i(cpu_fault_i), .alarm_clear_input_i(clr_in),
      .serial_reset_i(ser_rst), .brake_release_req_i(brake_req), .motor_stop_o(stop),
      .winding_enable_o(wind), .brake_release_o(brake), .supply_high_info_bit_o(hi),
      .supply_low_info_bit_o(lo), .alarm_code_o(code), .ind_red_o(red), .ind_blue_o(blue),
      .irq_o(irq), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
   mam_host host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .edge_req_i(edge_req),
      .serial_req_i(serial_req), .hold_i(hold), .alarm_clear_input_o(clr_in),
      .serial_reset_o(ser_rst));
   // verdict and end of run
   task conclude;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // hang guard
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors = errors + 1;
         conclude();
      end
   end
   // compare one flag
   task chk_bit(input logic got, input logic exp, input string what);
      check_count = check_count + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("CHECK FAILED %0t %s got %b want %b", $time, what, got, exp);
      end
   endtask
   // compare one word
   task chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count = check_count + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("CHECK FAILED %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // wait n edges and let their updates land
   task settle(input int k);
      repeat (k) @(posedge clk_sys_i);
      #1;
   endtask
   // one apb transfer: setup, then access until pready
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_sys_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      do @(posedge clk_sys_i); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd);
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000, rd);
      chk_word(rd & m, e, "register read");
   endtask
   // pulse a host request for one cycle
   task host_req(input logic ser);
      @(posedge clk_sys_i);
      if (ser) serial_req <= 1'b1;
      else edge_req <= 1'b1;
      @(posedge clk_sys_i);
      serial_req <= 1'b0;
      edge_req <= 1'b0;
      settle(4);
   endtask
   // count rising edges of red or blue over k cycles
   task blinks(input logic sel_red, input int k, output int cnt);
      logic prev;
      prev = sel_red ? red : blue; // a pulse already lit is not a new blink
      cnt = 0;
      repeat (k) begin
         settle(1);
         if ((sel_red ? red : blue) === 1'b1 && prev === 1'b0) cnt = cnt + 1;
         prev = sel_red ? red : blue;
      end
   endtask
   task drive_supply(input logic [9:0] v);
      @(posedge clk_sys_i);
      supply <= v;
      settle(3);
   endtask
   initial begin
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      settle(1);
      chk_bit(stop, 1'b0, "stop after reset");
      chk_bit(wind, 1'b1, "winding after reset");
      rd_chk(OFS_OV_THR, 32'hFFFF_FFFF, 32'h0000_0276);
      rd_chk(OFS_UV_THR, 32'hFFFF_FFFF, 32'h0000_008C);
      rd_chk(OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0000);
      rd_chk(OFS_IRQ_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
      apb(1'b0, 8'h20, 32'h0000_0000, rd);
      chk_bit(pslverr, 1'b1, "unmapped error");
      chk_word(rd, 32'h0000_0000, "unmapped read");
      $display("test reset done");
      wr(OFS_OV_THR, 32'h0000_0064);
      rd_chk(OFS_OV_THR, 32'hFFFF_FFFF, 32'h0000_008C);
      wr(OFS_OV_THR, 32'h0000_02BC);
      rd_chk(OFS_OV_THR, 32'hFFFF_FFFF, 32'h0000_0276);
      wr(OFS_IRQ_MASK, 32'h0000_0004);
      wr(OFS_OV_THR, 32'h0000_00C8);
      settle(3);
      chk_bit(hi, 1'b1, "high info set");
      chk_bit(irq, 1'b1, "irq high info");
      blinks(1'b0, 40, n);
      chk_word(n, 32'h0000_0001, "blue blinks");
      chk_bit(stop, 1'b0, "info keeps motor");
      wr(OFS_IRQ_STAT, 32'h0000_0004);
      settle(1);
      chk_bit(irq, 1'b0, "irq cleared");
      drive_supply(10'h0C8);
      chk_bit(hi, 1'b1, "high info at threshold");
      drive_supply(10'h0C7);
      chk_bit(hi, 1'b0, "high info cleared");
      wr(OFS_UV_THR, 32'h0000_012C);
      settle(3);
      chk_bit(lo, 1'b1, "low info set");
      drive_supply(10'h12D);
      chk_bit(lo, 1'b0, "low info cleared");
      wr(OFS_UV_THR, 32'h0000_008C);
      wr(OFS_OV_THR, 32'h0000_0276);
      wr(OFS_IRQ_MASK, 32'h0000_0000);
      $display("test information done");
      brake_req <= 1'b1;
      hold <= 1'b1;
      drive_supply(10'h168);
      chk_bit(stop, 1'b0, "no alarm at limit");
      drive_supply(10'h169);
      chk_word(code, ALM_CODE_OV, "ov code");
      chk_bit(stop, 1'b1, "alarm stops motor");
      chk_bit(wind, 1'b0, "alarm cuts winding");
      chk_bit(brake, 1'b0, "brake holds");
      chk_bit(irq, 1'b0, "masked irq");
      blinks(1'b1, 120, n);
      chk_word(n, 32'h0000_0009, "red blinks ov");
      rd_chk(OFS_STATUS, 32'h0000_FF03, 32'h0000_2201);
      rd_chk(OFS_IRQ_STAT, 32'h0000_0001, 32'h0000_0001);
      wr(OFS_IRQ_MASK, 32'h0000_0001);
      settle(1);
      chk_bit(irq, 1'b1, "unmasked irq");
      wr(OFS_IRQ_STAT, 32'h0000_0001);
      settle(1);
      chk_bit(irq, 1'b0, "irq w1c");
      drive_supply(10'h0F0);
      settle(10);
      chk_bit(stop, 1'b1, "held level no clear");
      @(posedge clk_sys_i);
      hold <= 1'b0;
      settle(2);
      host_req(1'b0);
      chk_bit(stop, 1'b0, "edge clears");
      chk_bit(brake, 1'b1, "brake follows request");
      chk_word(code, ALM_CODE_NONE, "code cleared");
      wr(OFS_CTRL, 32'h0000_0001);
      drive_supply(10'h258);
      chk_bit(stop, 1'b0, "mode48 no alarm");
      drive_supply(10'h277);
      chk_bit(stop, 1'b1, "mode48 alarm");
      drive_supply(10'h0F0);
      host_req(1'b1);
      chk_bit(stop, 1'b0, "serial clears");
      drive_supply(10'h277);
      chk_bit(stop, 1'b1, "mode48 alarm again");
      drive_supply(10'h0F0);
      wr(OFS_CTRL, 32'h0000_0003);
      settle(3);
      chk_bit(stop, 1'b0, "register clears");
      rd_chk(OFS_CTRL, 32'hFFFF_FFFF, 32'h0000_0001);
      $display("test overvoltage done");
      @(posedge clk_sys_i);
      cpu_fault_i <= 1'b1;
      settle(3);
      @(posedge clk_sys_i);
      cpu_fault_i <= 1'b0;
      chk_word(code, ALM_CODE_CPU, "cpu code");
      blinks(1'b1, 176, n);
      chk_word(n, 32'h0000_0012, "red blinks cpu");
      host_req(1'b0);
      host_req(1'b1);
      wr(OFS_CTRL, 32'h0000_0002);
      settle(3);
      chk_word(code, ALM_CODE_CPU, "cpu ignores resets");
      chk_bit(stop, 1'b1, "cpu alarm latched");
      @(posedge clk_sys_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      settle(2);
      chk_bit(stop, 1'b0, "power cycle clears");
      chk_word(code, ALM_CODE_NONE, "code after power cycle");
      $display("test cpu alarm done");
      conclude();
   end
endmodule
